// ===== rtl/adcsc_core.sv
// serial command decoder and configuration register bank of the adc
// assumes: host is spi master on sclk, drives din, samples dout on the
// falling edge; conversions and calibrations arrive on clk as pulses
//
// How it works
// - stop command ends automatic loading of results on dout
// - stop takes effect only at the next conversion-ready assertion
// - when stopped, results load only on the read-once command
// - read starts with 0010 nibble and a start address
// - second read byte low nibble plus one is register count
// - read addresses past the last register wrap to zero
// - bytes received during register readout are ignored
// - write starts with 0100 nibble and a start address
// - second write byte low nibble plus one is data byte count
// - system offset calibration updates offset coefficient
// - system gain calibration updates full-scale coefficient
// - self offset calibration shorts inputs to mid-supply first
// - all-ones byte does nothing
// - burnout select in bits 7:6, low bits fixed 000001
// - bias bits 1:0 for negative and positive input, rest zero
// - 24-bit coefficients lsb first, id and ready mode at 0xA
// - monitor register bit 7 shows the clock source status
// - continuous read is the reset mode, results auto-loaded
`timescale 1ns/1ps
`default_nettype none

module adcsc_core
  import adcsc_pkg::*;
#(
  parameter logic [3:0] ID_CODE = 4'h5, // arbitrary value
  parameter logic [23:0] FULL_RESET = 24'h400000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  input wire logic clock_source_status,
  input wire logic cal_done,
  input wire logic [23:0] cal_result,
  output logic conversion_ready_n,
  output logic cal_req,
  output adcsc_cal_e cal_kind,
  output logic input_short_mid,
  output adcsc_cfg_s cfg
);

  // link side, on sclk
  logic rst_link_q;
  logic lnk_clr;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_byte_q;
  logic rx_tgl_q;
  logic tk_tgl_q;
  logic [7:0] tx_sh_q;
  logic dout_q;

  // core side, on clk
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  logic tk_s1_q, tk_s2_q, tk_s3_q;
  logic cs_s1_q, cs_s2_q;
  logic rx_ev, tk_ev;
  logic [7:0] rxb;
  adcsc_state_e st_q;
  logic [4:0] left_q;
  logic [3:0] wptr_q;
  logic [3:0] rptr_q;
  logic [7:0] tx_hold_q;
  logic [7:0] regs_q [NREG];
  logic cont_q, stop_pend_q, cont_pend_q;
  logic [23:0] lat_q, res_q;
  logic [1:0] res_left_q;
  logic res_act_q;
  logic rdy_n_q;
  logic cal_busy_q, cal_req_q, short_q;
  adcsc_cal_e cal_kind_q;
  logic idle_cmd;
  logic ld_conv, ld_once;

  // one flop so the link resets from a registered source
  always_ff @(posedge clk) begin
    rst_link_q <= rst;
  end

  assign lnk_clr = rst_link_q | cs_n;

  // framing restarts on every chip-select deassertion
  always_ff @(posedge sclk or posedge lnk_clr) begin
    if (lnk_clr) begin
      bit_cnt_q <= FIRST_BIT;
    end else begin
      bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
    end
  end

  always_ff @(posedge sclk) begin
    rx_sh_q <= {rx_sh_q[6:0], din};
    if (bit_cnt_q == LAST_BIT) begin
      rx_byte_q <= {rx_sh_q[6:0], din};
    end
  end

  // toggles survive cs_n so no false events reach the core
  always_ff @(posedge sclk or posedge rst_link_q) begin
    if (rst_link_q) begin
      rx_tgl_q <= 1'b0;
      tk_tgl_q <= 1'b0;
      dout_q <= 1'b0;
      tx_sh_q <= IDLE_BYTE;
    end else begin
      if (bit_cnt_q == LAST_BIT) begin
        rx_tgl_q <= ~rx_tgl_q;
      end
      // tx_hold_q moves just after a take, and also on any result load, which can come at any time
      if (bit_cnt_q == FIRST_BIT) begin
        dout_q <= tx_hold_q[7];
        tx_sh_q <= {tx_hold_q[6:0], 1'b0};
        tk_tgl_q <= ~tk_tgl_q;
      end else begin
        dout_q <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  assign dout = dout_q;

  // crossings into clk
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
      tk_s1_q <= 1'b0;
      tk_s2_q <= 1'b0;
      tk_s3_q <= 1'b0;
      cs_s1_q <= 1'b0;
      cs_s2_q <= 1'b0;
    end else begin
      rx_s1_q <= rx_tgl_q;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      tk_s1_q <= tk_tgl_q;
      tk_s2_q <= tk_s1_q;
      tk_s3_q <= tk_s2_q;
      cs_s1_q <= clock_source_status;
      cs_s2_q <= cs_s1_q;
    end
  end

  assign rx_ev = rx_s2_q ^ rx_s3_q;
  assign tk_ev = tk_s2_q ^ tk_s3_q;
  // rx_byte_q is written on the same sclk edge as the toggle, two clk flops before it shows
  assign rxb = rx_byte_q;
  assign idle_cmd = rx_ev && (st_q == S_IDLE);
  assign ld_conv = conv_valid && cont_q && (st_q == S_IDLE);
  assign ld_once = idle_cmd && (rxb[7:1] == ONCE7);

  function automatic logic [7:0] rd_reg(input logic [3:0] a);
    if (a > A_LAST) begin
      return IDLE_BYTE;
    end else if (a == A_MUX) begin
      return {cs_s2_q, regs_q[a][6:0]};
    end else begin
      return regs_q[a];
    end
  endfunction : rd_reg

  function automatic logic [7:0] rst_val(input int a);
    case (a)
      A_BURN: return RST_BURN;
      A_FULL0: return FULL_RESET[7:0];
      A_FULL1: return FULL_RESET[15:8];
      A_FULL2: return FULL_RESET[23:16];
      A_ID: return {ID_CODE, 4'h0};
      default: return RST_ZERO;
    endcase
  endfunction : rst_val

  // command sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      left_q <= 5'h00;
      wptr_q <= 4'h0;
    end else if (rx_ev) begin
      case (st_q)
        S_IDLE: begin
          // no-op and the restricted code fall through here
          if (rxb[7:4] == NIB_RD) begin
            st_q <= S_RDCNT;
          end else if (rxb[7:4] == NIB_WR) begin
            st_q <= S_WRCNT;
            wptr_q <= rxb[3:0];
          end
        end
        S_RDCNT: begin
          st_q <= S_RDDAT;
          left_q <= 5'({1'b0, rxb[3:0]} + 5'h01);
        end
        S_RDDAT: begin
          // host bytes carry nothing here
          left_q <= 5'(left_q - 5'h01);
          if (left_q == 5'h01) begin
            st_q <= S_IDLE;
          end
        end
        S_WRCNT: begin
          st_q <= S_WRDAT;
          left_q <= 5'({1'b0, rxb[3:0]} + 5'h01);
        end
        S_WRDAT: begin
          wptr_q <= adcsc_next(wptr_q);
          left_q <= 5'(left_q - 5'h01);
          if (left_q == 5'h01) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // read mode: commands wait for the next ready assertion
  always_ff @(posedge clk) begin
    if (rst) begin
      cont_q <= 1'b1;
      stop_pend_q <= 1'b0;
      cont_pend_q <= 1'b0;
    end else begin
      if (conv_valid) begin
        if (stop_pend_q) begin
          cont_q <= 1'b0;
        end else if (cont_pend_q) begin
          cont_q <= 1'b1;
        end
        stop_pend_q <= 1'b0;
        cont_pend_q <= 1'b0;
      end
      // a command in the same cycle waits for the following ready
      if (idle_cmd && rxb[7:1] == STOP7) begin
        stop_pend_q <= 1'b1;
        cont_pend_q <= 1'b0;
      end else if (idle_cmd && rxb[7:1] == CONT7) begin
        cont_pend_q <= 1'b1;
        stop_pend_q <= 1'b0;
      end
    end
  end

  // outgoing byte, one byte ahead of the shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_hold_q <= IDLE_BYTE;
      rptr_q <= 4'h0;
      lat_q <= 24'h000000;
      res_q <= 24'h000000;
      res_left_q <= 2'h0;
      res_act_q <= 1'b0;
      rdy_n_q <= 1'b1;
    end else begin
      if (conv_valid) begin
        lat_q <= conv_data;
        rdy_n_q <= 1'b0;
      end
      if (idle_cmd && rxb[7:4] == NIB_RD) begin
        rptr_q <= rxb[3:0];
      end else if (ld_conv || ld_once) begin
        // stopped mode never reaches here without read-once
        res_q <= ld_conv ? conv_data : lat_q;
        tx_hold_q <= ld_conv ? conv_data[23:16] : lat_q[23:16];
        res_left_q <= 2'h2;
        res_act_q <= 1'b1;
      end else if (tk_ev && (st_q == S_RDCNT || st_q == S_RDDAT)) begin
        // the slot after the last counted register carries nothing
        if (st_q == S_RDDAT && left_q == 5'h01) begin
          tx_hold_q <= IDLE_BYTE;
        end else begin
          tx_hold_q <= rd_reg(rptr_q);
        end
        rptr_q <= adcsc_next(rptr_q);
        res_act_q <= 1'b0;
      end else if (tk_ev && res_act_q) begin
        res_left_q <= 2'(res_left_q - 2'h1);
        if (res_left_q == 2'h2) begin
          tx_hold_q <= res_q[15:8];
        end else if (res_left_q == 2'h1) begin
          tx_hold_q <= res_q[7:0];
        end else begin
          tx_hold_q <= IDLE_BYTE;
          res_act_q <= 1'b0;
          if (!conv_valid) begin
            rdy_n_q <= 1'b1;
          end
        end
      end else if (tk_ev) begin
        tx_hold_q <= IDLE_BYTE;
      end
    end
  end

  assign conversion_ready_n = rdy_n_q;

  // calibration control
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_busy_q <= 1'b0;
      cal_req_q <= 1'b0;
      short_q <= 1'b0;
      cal_kind_q <= K_NONE;
    end else begin
      cal_req_q <= 1'b0;
      if (cal_done && cal_busy_q) begin
        cal_busy_q <= 1'b0;
        short_q <= 1'b0;
      end else if (idle_cmd && !cal_busy_q) begin
        if (rxb == C_SYSO || rxb == C_SYSG || rxb == C_SELFO) begin
          cal_busy_q <= 1'b1;
          cal_req_q <= 1'b1;
          cal_kind_q <= adcsc_cal_e'(rxb[1:0]);
          short_q <= (rxb == C_SELFO);
        end
      end
    end
  end

  assign cal_req = cal_req_q;
  assign cal_kind = cal_kind_q;
  assign input_short_mid = short_q;

  // register bank
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= rst_val(i);
      end
    end else begin
      if (rx_ev && st_q == S_WRDAT && wptr_q <= A_LAST) begin
        // read-only bits keep their value whatever is written
        regs_q[wptr_q] <= (rxb & adcsc_wmask(wptr_q)) |
          (regs_q[wptr_q] & ~adcsc_wmask(wptr_q));
      end
      if (cal_done && cal_busy_q) begin
        if (cal_kind_q == K_SYSG) begin
          regs_q[A_FULL0] <= cal_result[7:0];
          regs_q[A_FULL1] <= cal_result[15:8];
          regs_q[A_FULL2] <= cal_result[23:16];
        end else begin
          regs_q[A_OFS0] <= cal_result[7:0];
          regs_q[A_OFS1] <= cal_result[15:8];
          regs_q[A_OFS2] <= cal_result[23:16];
        end
      end
    end
  end

  assign cfg.burnout_current_select = regs_q[A_BURN][7:6];
  assign cfg.input_bias_enable = regs_q[A_BIAS][1:0];
  assign cfg.monitor_select = regs_q[A_MUX][2:0];
  assign cfg.gain_rate = regs_q[A_GAIN];
  assign cfg.ready_output_mode = regs_q[A_ID][3];
  assign cfg.offset_coefficient =
    {regs_q[A_OFS2], regs_q[A_OFS1], regs_q[A_OFS0]};
  assign cfg.fullscale_coefficient =
    {regs_q[A_FULL2], regs_q[A_FULL1], regs_q[A_FULL0]};

  // checks, all on clk
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_stop_waits;
    idle_cmd && rxb[7:1] == STOP7 && cont_q && !conv_valid
      |=> cont_q [*1] ##1 (cont_q || $past(conv_valid));
  endproperty
  a_stop_waits: assert property (p_stop_waits)
    else $error("stop changed mode before ready");

  property p_stop_acts;
    stop_pend_q && conv_valid |=> !cont_q;
  endproperty
  a_stop_acts: assert property (p_stop_acts)
    else $error("stop did not end continuous read");

  property p_stopped_no_load;
    !cont_q && conv_valid && !res_act_q && !ld_once && !tk_ev
      |=> !res_act_q && tx_hold_q == $past(tx_hold_q);
  endproperty
  a_stopped_no_load: assert property (p_stopped_no_load)
    else $error("result loaded while stopped");

  property p_rd_start;
    idle_cmd && rxb[7:4] == NIB_RD
      |=> st_q == S_RDCNT && rptr_q == $past(rxb[3:0]);
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read command not decoded");

  property p_rd_count;
    rx_ev && st_q == S_RDCNT
      |=> st_q == S_RDDAT && left_q == $past(rxb[3:0]) + 5'h01;
  endproperty
  a_rd_count: assert property (p_rd_count)
    else $error("read count wrong");

  property p_wrap;
    tk_ev && st_q == S_RDDAT && rptr_q == A_LAST
      && !(idle_cmd) |=> rptr_q == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("read address did not wrap");

  property p_ignore;
    rx_ev && st_q == S_RDDAT && left_q > 5'h01
      |=> st_q == S_RDDAT && !cal_req_q && $stable(cont_pend_q);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("byte acted on during readout");

  property p_wr_store;
    rx_ev && st_q == S_WRDAT && wptr_q == A_BIAS
      |=> regs_q[A_BIAS] == ($past(rxb) & 8'h03);
  endproperty
  a_wr_store: assert property (p_wr_store)
    else $error("bias write not stored as masked");

  property p_cal_off;
    cal_done && cal_busy_q && cal_kind_q == K_SYSO
      |=> cfg.offset_coefficient == $past(cal_result);
  endproperty
  a_cal_off: assert property (p_cal_off)
    else $error("offset coefficient not updated");

  property p_self_short;
    idle_cmd && rxb == C_SELFO && !cal_busy_q && !cal_done
      |=> input_short_mid && cal_req ##1 !cal_req;
  endproperty
  a_self_short: assert property (p_self_short)
    else $error("self calibration did not short inputs");

  property p_nop;
    idle_cmd && rxb == C_NOP |=> st_q == S_IDLE && !cal_req_q;
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-op byte had an effect");

  property p_burn_fixed;
    regs_q[A_BURN][5:0] == BURN_FIXED;
  endproperty
  a_burn_fixed: assert property (p_burn_fixed)
    else $error("burnout fixed bits changed");

  property p_wr_end;
    rx_ev && st_q == S_WRDAT && left_q == 5'h01 |=> st_q == S_IDLE;
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write did not end after last byte");

  c_read: cover property (st_q == S_RDDAT ##[1:1000] st_q == S_IDLE);
  c_write: cover property (st_q == S_WRDAT ##[1:1000] st_q == S_IDLE);
  c_cal: cover property (cal_req_q ##[1:1000] cal_done);
  c_stop: cover property (stop_pend_q ##[1:1000] !cont_q);

endmodule : adcsc_core

`default_nettype wire

// ===== rtl/adcsc_pkg.sv
// constants, types and helper decoding for the serial command block
// assumes: 8-bit command bytes, register map from 0x0 to 0xA
package adcsc_pkg;

  localparam int NREG = 11;
  localparam int BYTE_W = 8;
  localparam int COEF_W = 24;

  // register offsets
  localparam logic [3:0] A_BURN = 4'h0;
  localparam logic [3:0] A_BIAS = 4'h1;
  localparam logic [3:0] A_MUX = 4'h2;
  localparam logic [3:0] A_GAIN = 4'h3;
  localparam logic [3:0] A_OFS0 = 4'h4;
  localparam logic [3:0] A_OFS1 = 4'h5;
  localparam logic [3:0] A_OFS2 = 4'h6;
  localparam logic [3:0] A_FULL0 = 4'h7;
  localparam logic [3:0] A_FULL1 = 4'h8;
  localparam logic [3:0] A_FULL2 = 4'h9;
  localparam logic [3:0] A_ID = 4'hA;
  localparam logic [3:0] A_LAST = 4'hA;

  // command encodings
  localparam logic [3:0] NIB_RD = 4'h2;
  localparam logic [3:0] NIB_WR = 4'h4;
  localparam logic [6:0] STOP7 = 7'h0B;
  localparam logic [6:0] CONT7 = 7'h0A;
  localparam logic [6:0] ONCE7 = 7'h09;
  localparam logic [7:0] C_SYSO = 8'h60;
  localparam logic [7:0] C_SYSG = 8'h61;
  localparam logic [7:0] C_SELFO = 8'h62;
  localparam logic [7:0] C_NOP = 8'hFF;
  localparam logic [7:0] C_RESTRICT = 8'hF1;

  // field layout and reset values
  localparam logic [7:0] RST_BURN = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [5:0] BURN_FIXED = 6'h01;
  localparam int CLK_SRC_BIT = 7;
  localparam int ID_LSB = 4;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RDCNT = 3'b001,
    S_RDDAT = 3'b010,
    S_WRCNT = 3'b011,
    S_WRDAT = 3'b100
  } adcsc_state_e;

  typedef enum logic [1:0] {
    K_SYSO  = 2'b00,
    K_SYSG  = 2'b01,
    K_SELFO = 2'b10,
    K_NONE  = 2'b11
  } adcsc_cal_e;

  typedef struct packed {
    logic [1:0] burnout_current_select;
    logic [1:0] input_bias_enable;
    logic [2:0] monitor_select;
    logic [7:0] gain_rate;
    logic ready_output_mode;
    logic [23:0] offset_coefficient;
    logic [23:0] fullscale_coefficient;
  } adcsc_cfg_s;

  // writable bits per register
  function automatic logic [7:0] adcsc_wmask(input logic [3:0] a);
    case (a)
      A_BURN: return 8'hC0;
      A_BIAS: return 8'h03;
      A_MUX: return 8'h07;
      A_GAIN: return 8'h7F;
      A_ID: return 8'h08;
      default: return (a <= A_LAST) ? 8'hFF : 8'h00;
    endcase
  endfunction : adcsc_wmask

  function automatic logic [3:0] adcsc_next(input logic [3:0] a);
    return (a >= A_LAST) ? 4'h0 : 4'(a + 4'h1);
  endfunction : adcsc_next

endpackage : adcsc_pkg

// ===== bench/adcsc_host.sv
// spi host model: makes the serial clock, select and data of each frame
// assumes: device samples din on rising sclk and updates dout after it
`timescale 1ns/1ps
`default_nettype none

module adcsc_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  localparam int HALF = 24;

  // clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
  end

  task automatic select(input logic on);
    #HALF;
    cs_n = ~on;
    // line left undriven has no pull, so show the opposite level
    if (!on) din = ~din;
    #HALF;
  endtask : select

  // msb first; the bench only hands over documented codes, never F1h
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #HALF;
      sclk = 1'b1;
      #HALF;
      rx[i] = dout;
      sclk = 1'b0;
    end
  endtask : xfer
endmodule : adcsc_host
`default_nettype wire

// ===== bench/adcsc_core_bench.sv
// testbench of the serial command block: map, read modes, calibration
// assumes: host model adcsc_host, core clock 100 MHz, sclk 48 ns
`timescale 1ns/1ps
`default_nettype none

module adcsc_core_bench
  import adcsc_pkg::*;
;
  localparam logic [3:0] ID = 4'h9; // arbitrary value
  localparam logic [23:0] FSR = 24'h3A5C71;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, din, dout;
  logic conv_valid = 1'b0;
  logic [23:0] conv_data = 24'h000000;
  logic clock_source_status = 1'b1;
  logic cal_done = 1'b0;
  logic [23:0] cal_result = 24'h000000;
  logic conversion_ready_n, cal_req, input_short_mid;
  adcsc_cal_e cal_kind;
  adcsc_cfg_s cfg;
  logic [7:0] cal_cnt = 8'h00;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] rst_map[11];
  logic [23:0] v;
  int failures = 0;
  int checks_done = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (cal_req === 1'b1) cal_cnt <= cal_cnt + 8'h01;

  adcsc_core #(.ID_CODE(ID), .FULL_RESET(FSR)) dut (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .conv_valid(conv_valid), .conv_data(conv_data),
    .clock_source_status(clock_source_status), .cal_done(cal_done),
    .cal_result(cal_result), .conversion_ready_n(conversion_ready_n),
    .cal_req(cal_req), .cal_kind(cal_kind),
    .input_short_mid(input_short_mid), .cfg(cfg)
  );

  adcsc_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // one select-framed burst of txq; the byte seen per slot lands in rxq
  task automatic frame();
    logic [7:0] r;
    rxq.delete();
    host.select(1'b1);
    foreach (txq[i]) begin
      host.xfer(txq[i], r);
      rxq.push_back(r);
    end
    host.select(1'b0);
    txq.delete();
    repeat (10) @(negedge clk);
  endtask : frame

  task automatic rd(input logic [3:0] a, input logic [3:0] n,
                    input logic [7:0] fill);
    txq.push_back({NIB_RD, a});
    txq.push_back({4'h0, n});
    for (int i = 0; i <= int'(n); i++) txq.push_back(fill);
    frame();
  endtask : rd

  task automatic conv(input logic [23:0] d);
    @(negedge clk);
    conv_valid = 1'b1;
    conv_data = d;
    @(negedge clk);
    conv_valid = 1'b0;
    repeat (5) @(negedge clk);
  endtask : conv

  // lead byte, then three no-ops; result read from slot at onwards
  task automatic fetch(input logic [7:0] lead, input int at);
    txq = '{lead, C_NOP, C_NOP, C_NOP};
    frame();
    v = {rxq[at], rxq[at + 1], rxq[at + 2]};
  endtask : fetch

  task automatic cal_step(input adcsc_cal_e k, input logic [7:0] cnt,
                          input logic [23:0] res);
    check("cal requests", 32'(cal_cnt), 32'(cnt));
    check("cal kind", 32'(cal_kind), 32'(k));
    check("mid-supply", 32'(input_short_mid), 32'(k == K_SELFO));
    @(negedge clk);
    cal_done = 1'b1;
    cal_result = res;
    @(negedge clk);
    cal_done = 1'b0;
    @(negedge clk);
    if (k == K_SYSG)
      check("fullscale", 32'(cfg.fullscale_coefficient), 32'(res));
    else
      check("offset", 32'(cfg.offset_coefficient), 32'(res));
  endtask : cal_step

  // generous bound: the whole sequence needs well under 100 us
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  initial begin
    rst_map = '{8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
      FSR[7:0], FSR[15:8], FSR[23:16], {ID, 4'h0}};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    rd(4'h0, A_LAST, C_NOP);
    foreach (rst_map[i])
      check("reset reg", 32'(rxq[2 + i]), 32'(rst_map[i]));
    conv(24'hC3A517);
    check("ready low", 32'(conversion_ready_n), 32'h0);
    fetch(C_NOP, 0);
    check("auto result", 32'(v), 32'hC3A517);
    check("ready high", 32'(conversion_ready_n), 32'h1);
    // stop: the next conversion still loads, the one after does not
    txq = '{8'h17};
    frame();
    conv(24'h5E0D99);
    fetch(C_NOP, 0);
    check("last auto", 32'(v), 32'h5E0D99);
    conv(24'h0F7E81);
    fetch(C_NOP, 0);
    check("stopped slots", 32'(v), 32'({3{IDLE_BYTE}}));
    rd(A_BURN, 4'h0, C_NOP);
    check("readback stopped", 32'(rxq[2]), 32'h01);
    fetch(8'h13, 1);
    check("read once", 32'(v), 32'h0F7E81);
    // start waits for one conversion as well
    txq = '{8'h15};
    frame();
    conv(24'h6D2C4B);
    fetch(C_NOP, 0);
    check("start waits", 32'(v), 32'({3{IDLE_BYTE}}));
    conv(24'h2B9E04);
    fetch(C_NOP, 0);
    check("restarted", 32'(v), 32'h2B9E04);
    txq = '{8'h16};
    frame();
    conv(24'h7C41E9);
    conv(24'h1D5F36);
    fetch(C_NOP, 0);
    check("stopped again", 32'(v), 32'h7C41E9);
    // write 0xA, 0x0 to 0x3 with wrap; a trailing byte is a new command
    txq = '{8'h4A, 8'h04, 8'hFF, 8'hBE, 8'hFE, 8'hFD, 8'hFF,
      C_SYSO};
    frame();
    check("burnout", 32'(cfg.burnout_current_select), 32'h2);
    check("bias", 32'(cfg.input_bias_enable), 32'h2);
    check("ready mode", 32'(cfg.ready_output_mode), 32'h1);
    check("monitor", 32'(cfg.monitor_select), 32'h5);
    check("gain rate", 32'(cfg.gain_rate), 32'h7F);
    clock_source_status = 1'b0;
    rd(4'h9, 4'h4, C_NOP);
    check("wrap read", {rxq[2], rxq[3], rxq[4], rxq[5]},
      {FSR[23:16], ID, 4'h8, 8'h81, 8'h02});
    check("clock status", 32'(rxq[6]), 32'h05);
    cal_step(K_SYSO, 8'h01, 24'hA1B2C3);
    txq = '{C_SYSG};
    frame();
    cal_step(K_SYSG, 8'h02, 24'h0F1E2D);
    txq = '{C_SELFO};
    frame();
    cal_step(K_SELFO, 8'h03, 24'h5A6B7C);
    // commands hidden in readout slots must do nothing
    rd(A_OFS0, 4'h5, C_SYSO);
    check("offset lsb first", 32'({rxq[4], rxq[3], rxq[2]}),
      32'h5A6B7C);
    check("fullscale lsb first", 32'({rxq[7], rxq[6], rxq[5]}),
      32'h0F1E2D);
    check("ignored in readout", 32'(cal_cnt), 32'h3);
    txq = '{C_NOP, C_NOP};
    frame();
    check("no-op", 32'(cal_cnt), 32'h3);
    check("no-op offset", 32'(cfg.offset_coefficient), 32'h5A6B7C);
    give_verdict();
  end
endmodule : adcsc_core_bench
`default_nettype wire
